// ### pkg/fsw_pkg.sv
// Shared constants and types for the flash self-write controller
package fsw_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [5:0] ADR_LO = 6'h00;
  localparam logic [5:0] ADR_HI = 6'h04;
  localparam logic [5:0] CTRL = 6'h08;
  localparam logic [5:0] KEY = 6'h0C;
  localparam logic [5:0] WORD = 6'h10;
  localparam logic [5:0] IRQ_STAT = 6'h14;
  localparam logic [5:0] IRQ_MASK = 6'h18;

  // Control register bit positions
  localparam int CTL_RSVD = 7;
  localparam int CTL_CFG_SEL = 6;
  localparam int CTL_LATCH_ONLY = 5;
  localparam int CTL_ERASE = 4;
  localparam int CTL_ERR = 3;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_WR = 1;
  localparam int CTL_RD = 0;

  // Interrupt status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;

  // Reset values
  localparam logic [7:0] ADR_LO_RST = 8'h00;
  localparam logic [6:0] ADR_HI_RST = 7'h00;
  localparam logic [13:0] WORD_RST = 14'h0000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic CTL_BIT_RST = 1'b0;

  // Unlock key pair
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Configuration space map, offsets from the space base
  localparam logic [14:0] CFG_UID_LAST = 15'h0003;
  localparam logic [14:0] CFG_DEVID = 15'h0006;
  localparam logic [14:0] CFG_WORD_LAST = 15'h0008;

  // Self-timed durations and their cycle counts
  localparam int CLK_MHZ = 40;
  localparam int PROG_TIME_US = 2;
  localparam int ERASE_TIME_US = 2;
  localparam logic [15:0] PROG_CYC = 16'(PROG_TIME_US * CLK_MHZ);
  localparam logic [15:0] ERASE_CYC = 16'(ERASE_TIME_US * CLK_MHZ);

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation sequencer states
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_LOAD = 2'b01,
    OP_PROG = 2'b10,
    OP_ERASE = 2'b11
  } fsw_op_e;

  // Unlock progress
  typedef enum logic [1:0] {
    UL_NONE = 2'b00,
    UL_HALF = 2'b01,
    UL_ARMED = 2'b10
  } fsw_unlock_e;

endpackage : fsw_pkg

// ### rtl/fsw_timer.sv
// Self-timing counter for program and erase cycles
`timescale 1ns/100ps
`default_nettype none
module fsw_timer (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic start, // Load count and run
  input wire logic [15:0] cycles, // Duration in clock cycles
  output logic done // Pulse on the last cycle
);
  logic [15:0] count;
  logic busy;

  // Done marks the last counted cycle, so the run lasts exactly the given cycles
  assign done = busy && (count == 16'h0001);

  // Count down while busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      busy <= 1'b0;
    end else begin
      if (start) begin
        count <= cycles;
        busy <= 1'b1;
      end else if (busy) begin
        count <= count - 16'h0001;
        busy <= (count != 16'h0001);
      end
    end
  end
endmodule : fsw_timer
`default_nettype wire

// ### rtl/fsw_ctrl.sv
// Flash self-write controller with AXI4-Lite register access
//
// How it works
// - Address low byte, read-write, reset zero
// - Address high seven bits, top reads one
// - Control top reads one; space select bit
// - Latch-only loads latch; else load then program
// - Erase select erases, cleared at completion
// - Erase ignores the latch-only bit
// - Error flag one on bad sequence
// - Any write-command set attempt while idle sets error
// - Program permit bit gates program and erase
// - Write command starts op, timed unless latch-only without erase, self-clears
// - Read command takes one cycle, self-clears
// - Key register write-only, resets to zero
// - Bad config-space read clears data word
// - User IDs writable; IDs, config read-only
// - Core stalls while timed write runs
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module fsw_ctrl (
  input wire logic CLK, // Core clock, 40 MHz
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic [5:0] AWADDR, // Write address
  input wire logic AWVALID, // Write address valid
  output logic AWREADY, // Write address ready
  input wire logic [31:0] WDATA, // Write data
  input wire logic [3:0] WSTRB, // Write byte strobes
  input wire logic WVALID, // Write data valid
  output logic WREADY, // Write data ready
  output logic [1:0] BRESP, // Write response
  output logic BVALID, // Write response valid
  input wire logic BREADY, // Write response ready
  input wire logic [5:0] ARADDR, // Read address
  input wire logic ARVALID, // Read address valid
  output logic ARREADY, // Read address ready
  output logic [31:0] RDATA, // Read data
  output logic [1:0] RRESP, // Read response
  output logic RVALID, // Read data valid
  input wire logic RREADY, // Read data ready
  output logic [14:0] FL_ADDR, // Flash word address
  output logic FL_CFG, // Configuration space select
  output logic FL_RD, // Array read strobe
  input wire logic [13:0] FL_RDATA, // Array read word
  output logic [13:0] FL_WDATA, // Word for the write latch
  output logic FL_LOAD, // Load addressed write latch
  output logic FL_PROG, // Program all latches
  output logic FL_ERASE, // Erase addressed row
  output logic CPU_STALL, // Hold the core
  output logic IRQ // Interrupt, active high
);
  import fsw_pkg::*;

  // Register offset decode
  function automatic logic reg_hit(input logic [5:0] a);
    reg_hit = (a == ADR_LO) || (a == ADR_HI) || (a == CTRL) || (a == KEY) ||
              (a == WORD) || (a == IRQ_STAT) || (a == IRQ_MASK);
  endfunction : reg_hit

  // Configuration locations that answer a read
  function automatic logic cfg_rd_ok(input logic [14:0] a);
    cfg_rd_ok = (a <= CFG_UID_LAST) || ((a >= CFG_DEVID) && (a <= CFG_WORD_LAST));
  endfunction : cfg_rd_ok

  // Configuration locations that accept program or erase
  function automatic logic cfg_wr_ok(input logic [14:0] a);
    cfg_wr_ok = (a <= CFG_UID_LAST);
  endfunction : cfg_wr_ok

  logic rst_q1;
  logic rst_n;
  logic aw_full;
  logic w_full;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [5:0] rd_addr;
  logic [7:0] adr_lo;
  logic [6:0] adr_hi;
  logic cfg_sel;
  logic latch_only;
  logic erase;
  logic err;
  logic permit;
  logic wr;
  logic rd;
  logic load;
  logic [13:0] word;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  fsw_op_e op;
  fsw_op_e next_op;
  fsw_unlock_e ul;
  logic tmr_done;

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Bus handshakes and register write strobes
  wire we = aw_full && w_full && !BVALID;
  wire [7:0] wd = w_data[7:0];
  wire b0 = we && w_strb[0];
  wire wr_adr_lo = b0 && (aw_addr == ADR_LO);
  wire wr_adr_hi = b0 && (aw_addr == ADR_HI);
  wire wr_ctl = b0 && (aw_addr == CTRL);
  wire wr_key = b0 && (aw_addr == KEY);
  wire wr_word_lo = b0 && (aw_addr == WORD);
  wire wr_word_hi = we && w_strb[1] && (aw_addr == WORD);
  wire wr_stat = b0 && (aw_addr == IRQ_STAT);
  wire wr_mask = b0 && (aw_addr == IRQ_MASK);
  wire ar_take = ARVALID && ARREADY;
  assign AWREADY = !aw_full;
  assign WREADY = !w_full;
  assign ARREADY = !RVALID;

  // Command qualification from the byte written to control
  wire idle = (op == OP_IDLE);
  wire [14:0] fl_addr = {adr_hi, adr_lo};
  wire space_ok = !wd[CTL_CFG_SEL] || cfg_wr_ok(fl_addr);
  wire armed = (ul == UL_ARMED);
  wire wr_try = wr_ctl && wd[CTL_WR] && idle;
  wire wr_ok = wr_try && armed && wd[CTL_PERMIT] && space_ok;
  wire rd_try = wr_ctl && wd[CTL_RD] && idle && !rd;
  wire op_done = (op == OP_LOAD) || tmr_done;
  wire run_timer = wr_ok && (wd[CTL_ERASE] || !wd[CTL_LATCH_ONLY]);
  wire [15:0] run_cycles = wd[CTL_ERASE] ? ERASE_CYC : PROG_CYC;
  wire rd_blank = cfg_sel && !cfg_rd_ok(fl_addr);
  wire [1:0] events = {wr_try && !wr_ok, op_done};

  // Register read view
  wire [7:0] ctl_view = {1'b1, cfg_sel, latch_only, erase, err, permit, wr, rd};
  wire [31:0] rd_val =
    (ARADDR == ADR_LO) ? {24'h000000, adr_lo} :
    (ARADDR == ADR_HI) ? {24'h000000, 1'b1, adr_hi} :
    (ARADDR == CTRL) ? {24'h000000, ctl_view} :
    (ARADDR == WORD) ? {18'h00000, word} :
    (ARADDR == IRQ_STAT) ? {30'h00000000, irq_stat} :
    (ARADDR == IRQ_MASK) ? {30'h00000000, irq_mask} :
    32'h00000000;

  // Write address and data holding, taken in either order
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (AWVALID && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= AWADDR;
      end else if (we) begin
        aw_full <= 1'b0;
      end
      if (WVALID && !w_full) begin
        w_full <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end else if (we) begin
        w_full <= 1'b0;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else if (we) begin
      BVALID <= 1'b1;
      BRESP <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // Read channel, answer one cycle after the address
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OKAY;
      rd_addr <= 6'h00;
    end else if (ar_take) begin
      RVALID <= 1'b1;
      RDATA <= rd_val;
      RRESP <= reg_hit(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      rd_addr <= ARADDR;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // Address pair
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      adr_lo <= ADR_LO_RST;
      adr_hi <= ADR_HI_RST;
    end else begin
      if (wr_adr_lo) begin
        adr_lo <= wd;
      end
      if (wr_adr_hi) begin
        adr_hi <= wd[6:0];
      end
    end
  end

  // Mode bits, held steady while an operation runs
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_sel <= CTL_BIT_RST;
      latch_only <= CTL_BIT_RST;
      permit <= CTL_BIT_RST;
      erase <= CTL_BIT_RST;
    end else begin
      if (wr_ctl && idle) begin
        cfg_sel <= wd[CTL_CFG_SEL];
        latch_only <= wd[CTL_LATCH_ONLY];
        permit <= wd[CTL_PERMIT];
      end
      if (op_done && (op == OP_ERASE)) begin
        erase <= 1'b0;
      end else if (wr_ctl && idle) begin
        erase <= wd[CTL_ERASE];
      end
    end
  end

  // Error flag and command bits
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      err <= CTL_BIT_RST;
      wr <= CTL_BIT_RST;
      rd <= CTL_BIT_RST;
    end else begin
      if (wr_try) begin
        err <= 1'b1;
      end else if (op_done) begin
        err <= 1'b0;
      end else if (wr_ctl) begin
        err <= wd[CTL_ERR];
      end
      if (wr_ok) begin
        wr <= 1'b1;
      end else if (op_done) begin
        wr <= 1'b0;
      end
      if (rd) begin
        rd <= 1'b0;
      end else if (rd_try) begin
        rd <= 1'b1;
      end
    end
  end

  // Unlock sequence tracker
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ul <= UL_NONE;
    end else if (wr_try) begin
      ul <= UL_NONE;
    end else if (wr_key) begin
      if (wd == KEY_FIRST) begin
        ul <= UL_HALF;
      end else if ((wd == KEY_SECOND) && (ul == UL_HALF)) begin
        ul <= UL_ARMED;
      end else begin
        ul <= UL_NONE;
      end
    end
  end

  // Operation sequencer next state
  always_comb begin
    next_op = op;
    case (op)
      OP_IDLE: begin
        if (wr_ok) begin
          if (wd[CTL_ERASE]) begin
            next_op = OP_ERASE;
          end else if (wd[CTL_LATCH_ONLY]) begin
            next_op = OP_LOAD;
          end else begin
            next_op = OP_PROG;
          end
        end
      end
      OP_LOAD: begin
        next_op = OP_IDLE;
      end
      OP_PROG, OP_ERASE: begin
        if (tmr_done) begin
          next_op = OP_IDLE;
        end
      end
      default: begin
        next_op = OP_IDLE;
      end
    endcase
  end

  // Sequencer state and latch load pulse
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      op <= OP_IDLE;
      load <= 1'b0;
    end else begin
      op <= next_op;
      load <= wr_ok && !wd[CTL_ERASE];
    end
  end

  // Program and erase duration
  fsw_timer u_timer (
    .clk(CLK),
    .rst_n(rst_n),
    .start(run_timer),
    .cycles(run_cycles),
    .done(tmr_done)
  );

  // Data word: array read result or software write
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      word <= WORD_RST;
    end else if (rd) begin
      word <= rd_blank ? WORD_RST : FL_RDATA;
    end else begin
      if (wr_word_lo) begin
        word[7:0] <= wd;
      end
      if (wr_word_hi) begin
        word[13:8] <= w_data[13:8];
      end
    end
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= IRQ_RST;
      irq_mask <= IRQ_RST;
      IRQ <= 1'b0;
    end else begin
      irq_stat <= events | (irq_stat & ~(wr_stat ? wd[1:0] : 2'h0));
      if (wr_mask) begin
        irq_mask <= wd[1:0];
      end
      IRQ <= |(irq_stat & irq_mask);
    end
  end

  // Flash array side
  assign FL_ADDR = fl_addr;
  assign FL_CFG = cfg_sel;
  assign FL_RD = rd;
  assign FL_WDATA = word;
  assign FL_LOAD = load;
  assign FL_PROG = (op == OP_PROG);
  assign FL_ERASE = (op == OP_ERASE);
  assign CPU_STALL = !idle;

  // Checks
  chk_adr_hi_top: assert property (@(posedge CLK) disable iff (!rst_n)
    RVALID && (rd_addr == ADR_HI) |-> RDATA[7])
    else $error("address high bit 7 not one");
  chk_ctl_top: assert property (@(posedge CLK) disable iff (!rst_n)
    RVALID && (rd_addr == CTRL) |-> RDATA[CTL_RSVD])
    else $error("control bit 7 not one");
  chk_rd_pulse: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(rd) |=> !rd ##1 !rd)
    else $error("read command not one cycle");
  chk_err_on_try: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_try |=> err)
    else $error("error flag not set on write attempt");
  chk_blocked_try: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_try && (!armed || !wd[CTL_PERMIT]) |=> idle && !wr && err)
    else $error("blocked command started");
  chk_erase_clear: assert property (@(posedge CLK) disable iff (!rst_n)
    (op == OP_ERASE) && tmr_done |=> !erase && !wr && idle)
    else $error("erase bit not cleared at end");
  chk_erase_mode: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_ok && wd[CTL_ERASE] |=> (op == OP_ERASE) && !FL_LOAD)
    else $error("erase not taken");
  chk_load_only: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_ok && !wd[CTL_ERASE] && wd[CTL_LATCH_ONLY] |=> FL_LOAD && (op == OP_LOAD) ##1 idle && !wr)
    else $error("latch load sequence wrong");
  chk_stall_run: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_ok && !wd[CTL_LATCH_ONLY] |=> CPU_STALL [*8])
    else $error("core not stalled");
  chk_cfg_blank: assert property (@(posedge CLK) disable iff (!rst_n)
    rd && rd_blank |=> (word == WORD_RST))
    else $error("blank config read not zero");
  chk_key_reset: assert property (@(posedge CLK) disable iff (!rst_n)
    wr_key && !wr_try && (wd != KEY_FIRST) && (wd != KEY_SECOND) |=> (ul == UL_NONE))
    else $error("bad key kept progress");
  chk_wr_end: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(wr) |-> $past(op_done) && !err)
    else $error("write bit cleared early");
endmodule : fsw_ctrl
`default_nettype wire

// ### verif/fsw_flash_model.sv
// Behavioural flash array and write latches facing the controller
`timescale 1ns/100ps
`default_nettype none
module fsw_flash_model #(
  parameter logic [13:0] DEV_ID = 14'h1C3A // Arbitrary device code
) (
  input wire logic clk, // Core clock
  input wire logic [14:0] addr, // Word address
  input wire logic cfg, // Configuration space
  input wire logic rd, // Read strobe
  input wire logic [13:0] wdata, // Latch data
  input wire logic load, // Load one latch
  input wire logic prog, // Program all latches
  input wire logic erase, // Erase the row
  output logic [13:0] rdata // Array word
);
  logic [13:0] mem [16];
  logic [13:0] latch [16];
  logic prog_q = 1'h0;
  logic [13:0] word;
  // Word only valid under the read strobe, inverted otherwise
  assign word = cfg ? ((addr[3:0] == 4'h6) ? DEV_ID : 14'h2AAA) : mem[addr[3:0]];
  assign rdata = rd ? word : ~word;
  // Array starts cleared, latches erased
  initial begin
    foreach (mem[i]) mem[i] = 14'h0000;
    foreach (latch[i]) latch[i] = 14'h3FFF;
  end
  // Latch load, row erase, commit at the end of programming
  always @(posedge clk) begin
    prog_q <= prog;
    if (load) latch[addr[3:0]] <= wdata;
    if (erase) foreach (mem[i]) mem[i] <= 14'h3FFF;
    if (prog_q && !prog) foreach (mem[i]) mem[i] <= latch[i];
  end
endmodule : fsw_flash_model
`default_nettype wire

// ### verif/tb_flash_self_write_control.sv
// Self-checking bench for the flash self-write controller
`timescale 1ns/100ps
`default_nettype none
module tb_flash_self_write_control;
  import fsw_pkg::*;
  logic CLK = 1'h0;
  logic RST_N = 1'h0;
  logic [5:0] AWADDR = 6'h00;
  logic [5:0] ARADDR = 6'h00;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic [31:0] WDATA = 32'h00000000;
  logic [3:0] WSTRB = 4'h3;
  wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FL_CFG, FL_RD, FL_LOAD, FL_PROG, FL_ERASE, CPU_STALL, IRQ;
  wire logic [1:0] BRESP, RRESP;
  wire logic [31:0] RDATA;
  wire logic [14:0] FL_ADDR;
  wire logic [13:0] FL_RDATA, FL_WDATA;
  int n_mismatch = 0, n_compared = 0, n_load, n_prog, n_erase, n_rd, n_stall;
  logic [31:0] rdat;

  fsw_ctrl fsw_ctrl_inst (.CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .FL_ADDR, .FL_CFG, .FL_RD, .FL_RDATA, .FL_WDATA, .FL_LOAD, .FL_PROG, .FL_ERASE, .CPU_STALL, .IRQ);
  fsw_flash_model fsw_flash_model_inst (.clk(CLK), .addr(FL_ADDR), .cfg(FL_CFG), .rd(FL_RD), .wdata(FL_WDATA),
    .load(FL_LOAD), .prog(FL_PROG), .erase(FL_ERASE), .rdata(FL_RDATA));

  // Clock at 40 MHz
  always #12.5 CLK = ~CLK;

  // Counts the cycles of each array strobe
  always @(posedge CLK) begin
    if (FL_LOAD === 1'h1) n_load++;
    if (FL_PROG === 1'h1) n_prog++;
    if (FL_ERASE === 1'h1) n_erase++;
    if (FL_RD === 1'h1) n_rd++;
    if (CPU_STALL === 1'h1) n_stall++;
  end

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tmo(input string nm);
    n_mismatch++;
    $display("[ERR] %s expected answer seen timeout", nm);
    test_done();
  endtask : tmo

  // Bus write: address and data offered together, released when taken
  task automatic bw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    for (i = 0; i < 100; i++) begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'h0;
      if (WVALID && WREADY) WVALID <= 1'h0;
      if (BVALID === 1'h1) break;
    end
    if (i == 100) tmo("write");
    BREADY <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, BRESP});
  endtask : bw

  // Bus read: result left in rdat
  task automatic br(input logic [5:0] a, input logic [1:0] er);
    int i;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    for (i = 0; i < 100; i++) begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'h0;
      if (RVALID === 1'h1) break;
    end
    if (i == 100) tmo("read");
    RREADY <= 1'h0;
    rdat = RDATA;
    chk("rresp", {30'h0, er}, {30'h0, RRESP});
  endtask : br

  task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] exp, input logic [31:0] msk);
    br(a, RESP_OKAY);
    chk(nm, exp, rdat & msk);
  endtask : rc

  // Optional key pair, then control write, then wait for the core to run again
  task automatic go(input logic ul, input logic [7:0] c);
    int i;
    if (ul) begin
      bw(KEY, {24'h000000, KEY_FIRST}, RESP_OKAY);
      bw(KEY, {24'h000000, KEY_SECOND}, RESP_OKAY);
    end
    n_load = 0;
    n_prog = 0;
    n_erase = 0;
    n_rd = 0;
    n_stall = 0;
    bw(CTRL, {24'h000000, c}, RESP_OKAY);
    for (i = 0; i < 400; i++) begin
      @(posedge CLK);
      if (CPU_STALL === 1'h0) break;
    end
    if (i == 400) tmo("idle");
    repeat (2) @(posedge CLK);
  endtask : go

  // Refused command: error up, no array activity, fail event
  task automatic refused();
    rc("ctrl_err", CTRL, 32'h08, 32'h0A);
    chk("no_op", 0, n_load + n_prog + n_erase + n_stall);
    rc("stat_fail", IRQ_STAT, 32'h02, 32'h03);
  endtask : refused

  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'h1;
    repeat (3) @(posedge CLK);
    rc("adr_lo", ADR_LO, 32'h00, 32'hFF);
    rc("adr_hi", ADR_HI, 32'h80, 32'hFF);
    rc("ctrl", CTRL, 32'h80, 32'hFF);
    rc("key", KEY, 32'h00, 32'hFF);
    br(6'h1C, RESP_SLVERR);
    bw(6'h1C, 32'hFF, RESP_SLVERR);
    bw(ADR_LO, 32'hA5, RESP_OKAY);
    bw(ADR_HI, 32'hFF, RESP_OKAY);
    rc("adr_lo", ADR_LO, 32'hA5, 32'hFF);
    rc("adr_hi", ADR_HI, 32'hFF, 32'hFF);
    chk("fl_addr", 32'h7FA5, {17'h0, FL_ADDR});
    bw(ADR_HI, 32'h00, RESP_OKAY);
    bw(ADR_LO, 32'h03, RESP_OKAY);
    bw(IRQ_MASK, 32'h00, RESP_OKAY);
    go(1'h0, 8'h06);
    refused();
    chk("irq_masked", 0, {31'h0, IRQ});
    bw(IRQ_MASK, 32'h03, RESP_OKAY);
    repeat (2) @(posedge CLK);
    chk("irq", 1, {31'h0, IRQ});
    bw(IRQ_STAT, 32'h03, RESP_OKAY);
    repeat (2) @(posedge CLK);
    chk("irq_clr", 0, {31'h0, IRQ});
    go(1'h1, 8'h02);
    refused();
    bw(IRQ_STAT, 32'h03, RESP_OKAY);
    bw(KEY, {24'h000000, KEY_FIRST}, RESP_OKAY);
    bw(KEY, 32'h12, RESP_OKAY);
    bw(KEY, {24'h000000, KEY_SECOND}, RESP_OKAY);
    go(1'h0, 8'h06);
    refused();
    bw(IRQ_STAT, 32'h03, RESP_OKAY);
    go(1'h1, 8'h36);
    chk("erase_cyc", ERASE_CYC, n_erase);
    chk("erase_ld", 0, n_load + n_prog);
    rc("ctrl", CTRL, 32'hA4, 32'hFF);
    rc("stat_done", IRQ_STAT, 32'h01, 32'h03);
    bw(IRQ_STAT, 32'h03, RESP_OKAY);
    go(1'h0, 8'h05);
    chk("rd_cyc", 1, n_rd);
    rc("erased", WORD, 32'h3FFF, 32'h3FFF);
    rc("ctrl", CTRL, 32'h84, 32'hFF);
    bw(WORD, 32'h1234, RESP_OKAY);
    go(1'h1, 8'h26);
    chk("ld_only", 1, n_load);
    chk("ld_noprog", 0, n_prog);
    rc("ctrl", CTRL, 32'hA4, 32'hFF);
    bw(ADR_LO, 32'h04, RESP_OKAY);
    bw(WORD, 32'h0ABC, RESP_OKAY);
    go(1'h1, 8'h06);
    chk("prog_ld", 1, n_load);
    chk("prog_cyc", PROG_CYC, n_prog);
    chk("stall", 1, {31'h0, n_stall >= PROG_CYC});
    rc("ctrl", CTRL, 32'h84, 32'hFF);
    go(1'h0, 8'h05);
    rc("word4", WORD, 32'h0ABC, 32'h3FFF);
    bw(ADR_LO, 32'h03, RESP_OKAY);
    go(1'h0, 8'h05);
    rc("word3", WORD, 32'h1234, 32'h3FFF);
    bw(ADR_LO, 32'h06, RESP_OKAY);
    go(1'h0, 8'h45);
    rc("dev_id", WORD, {18'h0, fsw_flash_model_inst.DEV_ID}, 32'h3FFF);
    bw(ADR_LO, 32'h05, RESP_OKAY);
    go(1'h0, 8'h45);
    rc("cfg_hole", WORD, 32'h0, 32'h3FFF);
    bw(IRQ_STAT, 32'h03, RESP_OKAY);
    bw(ADR_LO, 32'h06, RESP_OKAY);
    go(1'h1, 8'h46);
    refused();
    test_done();
  end
endmodule : tb_flash_self_write_control
`default_nettype wire
